// File: fcs_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_bus_master
   import fcs_pkg::*;
#(
   parameter int WDOG_PERIOD = WDOG_CYCLES
)
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   fcs_if.master            link,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp
);
   localparam int WCNT_W = $clog2(WDOG_PERIOD + 1);
   localparam logic [WCNT_W-1:0] WCNT_LAST = WCNT_W'(WDOG_PERIOD - 1);
   localparam logic [WCNT_W-1:0] WCNT_ZERO = '0;

   logic [15:0]       cmd_q;
   logic              wdog_en_q;
   logic              wdog_bit_q;
   logic [WCNT_W-1:0] wdog_cnt_q;
   logic              wr_pend_q;
   logic [7:0]        wr_addr_q;
   logic [31:0]       hrdata_q;
   logic [31:0]       rd_d;
   logic              addr_ok;
   logic [15:0]       cmd_out;

   // valid address phase
   assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

   // read mux, unmapped reads zero
   always_comb
   begin
      rd_d = 32'h00000000;
      if (haddr == OFS_CMD)
         rd_d = {16'h0000, cmd_q};
      else if (haddr == OFS_STAT)
         rd_d = {16'h0000, link.fieldbus_drive_state_word};
      else if (haddr == OFS_TRIG)
         rd_d = {16'h0000, link.logger_trigger_flags};
      else if (haddr == OFS_WDOG)
         rd_d = {31'h00000000, wdog_en_q};
      else if (haddr == OFS_ECHO)
         rd_d = {31'h00000000, link.fieldbus_drive_state_word[ST_VIN1_ECHO] == wdog_bit_q};
   end

   // address phase capture and read data
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q  <= 32'h00000000;
      end
      else
      begin
         wr_pend_q <= addr_ok & hwrite;
         if (addr_ok)
            wr_addr_q <= haddr;
         if (addr_ok && !hwrite)
            hrdata_q <= rd_d;
      end
   end

   // data phase writes; stop bits reset high
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cmd_q     <= CMD_RESET;
         wdog_en_q <= 1'b0;
      end
      else if (wr_pend_q)
      begin
         if (wr_addr_q == OFS_CMD)
            cmd_q <= hwdata[15:0];
         else if (wr_addr_q == OFS_WDOG)
            wdog_en_q <= hwdata[0];
      end
   end

   // watchdog pulse toggler on the first virtual input
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         wdog_cnt_q <= WCNT_ZERO;
         wdog_bit_q <= 1'b0;
      end
      else if (!wdog_en_q)
      begin
         wdog_cnt_q <= WCNT_ZERO;
         wdog_bit_q <= cmd_q[CMD_VIN_LO];
      end
      else if (wdog_cnt_q == WCNT_LAST)
      begin
         wdog_cnt_q <= WCNT_ZERO;
         wdog_bit_q <= ~wdog_bit_q;
      end
      else
      begin
         wdog_cnt_q <= wdog_cnt_q + WCNT_W'(1);
      end
   end

   // command word with watchdog bit merged
   always_comb
   begin
      cmd_out             = cmd_q;
      cmd_out[CMD_VIN_LO] = wdog_bit_q;
   end

   // registered link word
   logic [15:0] link_cmd_q;
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         link_cmd_q <= CMD_RESET;
      else
         link_cmd_q <= cmd_out;
   end

   assign link.fieldbus_command_word = link_cmd_q;
   assign hrdata    = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;
endmodule
`default_nettype wire

// File: fcs_drive_end.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_drive_end
   import fcs_pkg::*;
#(
   parameter int SAMPLE_CYCLES = FREQ_SAMPLE_CYCLES
)
(
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   fcs_if.drive                    link,
   input  wire logic               bypass_mode,
   input  wire logic               status_word_select,
   input  wire logic [15:0]        app_status_word,
   input  wire logic               local_on,
   input  wire logic               local_fault_reset,
   input  wire logic               ready_switch_on,
   input  wire logic               ready_operate,
   input  wire logic               running,
   input  wire logic               fault_active,
   input  wire logic               warning_active,
   input  wire logic               auto_reset_fault,
   input  wire logic               switch_inhibit,
   input  wire logic               speed_at_ref,
   input  wire logic               fout_over_fmax,
   input  wire logic signed [15:0] freq_ref,
   output logic                    drive_on,
   output logic                    coast_stop,
   output logic                    ramp_stop,
   output logic                    fault_reset,
   output logic [3:0]              bus_virtual_inputs,
   output logic signed [31:0]      freq_delta
);
   // samples per second of the delta window
   localparam int SAMPLES_PER_S = NS_PER_S / (SAMPLE_CYCLES * CLK_PERIOD_NS);
   localparam logic signed [31:0] SPS_W = 32'(SAMPLES_PER_S);
   localparam int SCNT_W = $clog2(SAMPLE_CYCLES + 1);
   localparam logic [SCNT_W-1:0] SCNT_LAST = SCNT_W'(SAMPLE_CYCLES - 1);
   localparam logic [SCNT_W-1:0] SCNT_ZERO = '0;

   logic [15:0]              cmd;
   logic                     drive_on_q;
   logic                     drive_on_d;
   logic                     coast_stop_q;
   logic                     coast_stop_d;
   logic                     ramp_stop_q;
   logic                     ramp_stop_d;
   logic                     fault_reset_q;
   logic                     fault_reset_d;
   logic                     reset_bit_prev_q;
   logic [3:0]               vin_q;
   logic [3:0]               vin_d;
   logic [15:0]              profile_word;
   logic [15:0]              state_word_q;
   logic [15:0]              trig_word_q;
   logic [15:0]              trig_word_d;
   logic [SCNT_W-1:0]        sample_cnt_q;
   logic signed [15:0]       freq_prev_q;
   logic signed [31:0]       freq_delta_q;
   logic signed [31:0]       freq_diff;

   assign cmd = link.fieldbus_command_word;

   // command decode, bus word replaces local control in bypass
   always_comb
   begin
      if (bypass_mode)
      begin
         // on only while coast and ramp stop bits are released
         drive_on_d    = cmd[CMD_ON] & cmd[CMD_NO_COAST] & cmd[CMD_NO_RAMP];
         coast_stop_d  = ~cmd[CMD_NO_COAST];
         ramp_stop_d   = ~cmd[CMD_NO_RAMP];
         fault_reset_d = cmd[CMD_FLT_RESET] & ~reset_bit_prev_q;
         vin_d         = cmd[CMD_VIN_LO +: CMD_VIN_N];
      end
      else
      begin
         drive_on_d    = local_on;
         coast_stop_d  = 1'b0;
         ramp_stop_d   = 1'b0;
         fault_reset_d = local_fault_reset;
         vin_d         = 4'h0;
      end
   end

   // registered control outputs
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         drive_on_q    <= 1'b0;
         coast_stop_q  <= 1'b0;
         ramp_stop_q   <= 1'b0;
         fault_reset_q <= 1'b0;
         vin_q         <= 4'h0;
      end
      else
      begin
         drive_on_q    <= drive_on_d;
         coast_stop_q  <= coast_stop_d;
         ramp_stop_q   <= ramp_stop_d;
         fault_reset_q <= fault_reset_d;
         vin_q         <= vin_d;
      end
   end

   // previous level of the reset bit; starts high so a held bit gives no pulse
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         reset_bit_prev_q <= 1'b1;
      end
      else
      begin
         reset_bit_prev_q <= cmd[CMD_FLT_RESET];
      end
   end

   // profile type drive state word
   always_comb
   begin
      profile_word               = WORD_ZERO; // unused bits zero
      profile_word[ST_RDY_ON]    = ready_switch_on;
      profile_word[ST_RDY_OP]    = ready_operate;
      profile_word[ST_RUNNING]   = running;
      profile_word[ST_FAULT]     = fault_active;
      profile_word[ST_NO_COAST]  = ~coast_stop_q;
      profile_word[ST_NO_QUICK]  = ~ramp_stop_q;
      profile_word[ST_INHIBIT]   = switch_inhibit;
      profile_word[ST_WARNING]   = warning_active;
      profile_word[ST_AT_REF]    = speed_at_ref;
      profile_word[ST_BUS_CTRL]  = bypass_mode & cmd[CMD_BUS_CTRL];
      profile_word[ST_OVER_FMAX] = fout_over_fmax;
      profile_word[ST_VIN1_ECHO] = vin_q[0];
   end

   // state word register, refreshed every cycle
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_word_q <= WORD_ZERO;
      end
      else if (status_word_select)
      begin
         state_word_q <= profile_word;
      end
      else
      begin
         state_word_q <= app_status_word;
      end
   end

   // logger trigger conditions
   always_comb
   begin
      trig_word_d               = WORD_ZERO;
      trig_word_d[TRG_FAULT]    = fault_active;
      trig_word_d[TRG_WARN]     = warning_active;
      trig_word_d[TRG_AUTO]     = auto_reset_fault;
      trig_word_d[TRG_FLT_WARN] = fault_active | warning_active;
      trig_word_d[TRG_FLT_AUTO] = fault_active | auto_reset_fault;
   end

   // logger trigger register
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         trig_word_q <= WORD_ZERO;
      end
      else
      begin
         trig_word_q <= trig_word_d;
      end
   end

   // difference over one sample window, scaled to per second
   assign freq_diff = 32'(freq_ref) - 32'(freq_prev_q);

   // sample window counter
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         sample_cnt_q <= SCNT_ZERO;
      end
      else if (sample_cnt_q == SCNT_LAST)
      begin
         sample_cnt_q <= SCNT_ZERO;
      end
      else
      begin
         sample_cnt_q <= sample_cnt_q + SCNT_W'(1);
      end
   end

   // frequency delta update at the end of each window
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         freq_prev_q  <= 16'sh0000;
         freq_delta_q <= 32'sh00000000;
      end
      else if (sample_cnt_q == SCNT_LAST)
      begin
         freq_prev_q  <= freq_ref;
         freq_delta_q <= 32'(freq_diff * SPS_W);
      end
   end

   assign link.fieldbus_drive_state_word = state_word_q;
   assign link.logger_trigger_flags      = trig_word_q;
   assign drive_on                       = drive_on_q;
   assign coast_stop                     = coast_stop_q;
   assign ramp_stop                      = ramp_stop_q;
   assign fault_reset                    = fault_reset_q;
   assign bus_virtual_inputs             = vin_q;
   assign freq_delta                     = freq_delta_q;
endmodule
`default_nettype wire

// File: fcs_dummy_end_marker.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: fcs_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fcs_if;
   // process data words between master and drive
   logic [15:0] fieldbus_command_word;
   logic [15:0] fieldbus_drive_state_word;
   logic [15:0] logger_trigger_flags;
   modport drive
   (
      input  fieldbus_command_word,
      output fieldbus_drive_state_word,
      output logger_trigger_flags
   );
   modport master
   (
      output fieldbus_command_word,
      input  fieldbus_drive_state_word,
      input  logger_trigger_flags
   );
endinterface
`default_nettype wire

// File: fcs_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_link_checker
(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic [15:0] fieldbus_command_word,
   input wire logic [15:0] fieldbus_drive_state_word,
   input wire logic [15:0] logger_trigger_flags,
   input wire logic        bypass_mode,
   input wire logic        status_word_select,
   input wire logic [15:0] app_status_word,
   input wire logic        fault_active,
   input wire logic        warning_active,
   input wire logic        auto_reset_fault
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [2:0]  age_q;
   logic        up;
   logic [15:0] cw;
   logic [15:0] sw;
   logic [15:0] tw;
   // short views of the link words
   assign cw = fieldbus_command_word;
   assign sw = fieldbus_drive_state_word;
   assign tw = logger_trigger_flags;
   // cycles since reset release, saturating
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         age_q <= 3'h0;
      else if (age_q != 3'h7)
         age_q <= age_q + 3'h1;
   end
   assign up = (age_q >= 3'h3);
   // bypass with profile word held for three cycles
   sequence s_byp;
      (up && bypass_mode && status_word_select)[*3];
   endsequence
   property p_coast;
      s_byp |-> sw[4] == $past(cw[1], 2);
   endproperty
   a_coast : assert property (p_coast) else $error("coast bit wrong");
   property p_quick;
      s_byp |-> sw[5] == $past(cw[2], 2);
   endproperty
   a_quick : assert property (p_quick) else $error("quick stop bit wrong");
   property p_echo;
      s_byp |-> sw[15] == $past(cw[11], 2);
   endproperty
   a_echo : assert property (p_echo) else $error("echo bit wrong");
   property p_busctl;
      up && $past(status_word_select) |-> sw[9] == $past(bypass_mode && cw[10]);
   endproperty
   a_busctl : assert property (p_busctl) else $error("bus control bit wrong");
   property p_sel;
      up && !$past(status_word_select) |-> sw == $past(app_status_word);
   endproperty
   a_sel : assert property (p_sel) else $error("state word source wrong");
   property p_unused;
      up && $past(status_word_select) |-> sw[14:11] == 4'h0 && tw[15:5] == 11'h0;
   endproperty
   a_unused : assert property (p_unused) else $error("unused bits set");
   property p_trig;
      up |-> tw[2:0] == $past({auto_reset_fault, warning_active, fault_active});
   endproperty
   a_trig : assert property (p_trig) else $error("trigger bits wrong");
   property p_or_fw;
      up |-> tw[3] == $past(fault_active || warning_active);
   endproperty
   a_or_fw : assert property (p_or_fw) else $error("fault or warning bit wrong");
   property p_or_fa;
      up |-> tw[4] == $past(fault_active || auto_reset_fault);
   endproperty
   a_or_fa : assert property (p_or_fa) else $error("fault or auto bit wrong");
endmodule
`default_nettype wire

// File: fcs_pkg.sv
`default_nettype none
package fcs_pkg;
   // clock
   localparam int CLK_PERIOD_NS = 10;
   // word width on the link
   localparam int WORD_W = 16;
   // command word bit positions
   localparam int CMD_ON        = 0;
   localparam int CMD_NO_COAST  = 1;
   localparam int CMD_NO_RAMP   = 2;
   localparam int CMD_FLT_RESET = 7;
   localparam int CMD_BUS_CTRL  = 10;
   localparam int CMD_VIN_LO    = 11;
   localparam int CMD_VIN_N     = 4;
   // drive state word bit positions
   localparam int ST_RDY_ON     = 0;
   localparam int ST_RDY_OP     = 1;
   localparam int ST_RUNNING    = 2;
   localparam int ST_FAULT      = 3;
   localparam int ST_NO_COAST   = 4;
   localparam int ST_NO_QUICK   = 5;
   localparam int ST_INHIBIT    = 6;
   localparam int ST_WARNING    = 7;
   localparam int ST_AT_REF     = 8;
   localparam int ST_BUS_CTRL   = 9;
   localparam int ST_OVER_FMAX  = 10;
   localparam int ST_VIN1_ECHO  = 15;
   // logger trigger bit positions
   localparam int TRG_FAULT     = 0;
   localparam int TRG_WARN      = 1;
   localparam int TRG_AUTO      = 2;
   localparam int TRG_FLT_WARN  = 3;
   localparam int TRG_FLT_AUTO  = 4;
   // reset values
   localparam logic [15:0] CMD_RESET  = 16'h0006;
   localparam logic [15:0] WORD_ZERO  = 16'h0000;
   // frequency delta sampling: 1 ms window
   localparam int FREQ_SAMPLE_NS     = 1000000;
   localparam int FREQ_SAMPLE_CYCLES = FREQ_SAMPLE_NS / CLK_PERIOD_NS;
   localparam int NS_PER_S           = 1000000000;
   // watchdog toggle period of the master end: 10 us
   localparam int WDOG_PERIOD_NS     = 10000;
   localparam int WDOG_CYCLES        = WDOG_PERIOD_NS / CLK_PERIOD_NS;
   // master end register offsets (bytes)
   localparam logic [7:0] OFS_CMD    = 8'h00;
   localparam logic [7:0] OFS_STAT   = 8'h04;
   localparam logic [7:0] OFS_TRIG   = 8'h08;
   localparam logic [7:0] OFS_WDOG   = 8'h0C;
   localparam logic [7:0] OFS_ECHO   = 8'h10;
   // ahb encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
   localparam logic       HRESP_OKAY    = 1'h0;
endpackage
`default_nettype wire

// File: tb_fieldbus_control_status_words.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fieldbus_control_status_words;
   import fcs_pkg::*;
   localparam int SAMP = 100;
   localparam int WDP  = 8;
   localparam int SCL  = NS_PER_S / (SAMP * CLK_PERIOD_NS);
   typedef struct packed {logic [15:0] cmd; logic [8:0] sts; logic [6:0] outs;} fcs_row_t;
   // command, status inputs, expected {vin, ramp, coast, on}
   localparam fcs_row_t ROWS [7] = '{'{16'h0007, 9'h003, 7'h01}, '{16'h0006, 9'h008, 7'h00},
      '{16'h0005, 9'h010, 7'h02}, '{16'h0003, 9'h020, 7'h04}, '{16'h7C07, 9'h1C4, 7'h79},
      '{16'h0807, 9'h018, 7'h09}, '{16'h4000, 9'h0FF, 7'h46}};
   logic               ref_clk = 1'b0;
   logic               rst_n   = 1'b0;
   logic               byp     = 1'b1;
   logic               sel     = 1'b1;
   logic               lon     = 1'b1; // local inputs set, ignored in bypass
   logic               lfr     = 1'b1;
   logic [15:0]        app     = 16'h0;
   logic [8:0]         sts     = 9'h0;
   logic signed [15:0] fref    = 16'sd10;
   logic               hsel    = 1'b0;
   logic [7:0]         haddr   = 8'h0;
   logic [1:0]         htrans  = 2'h0;
   logic               hwrite  = 1'b0;
   logic [2:0]         hsize   = 3'h2;
   logic [31:0]        hwdata  = 32'h0;
   logic [31:0]        hrdata;
   logic               hreadyout;
   logic               hresp;
   logic               drive_on;
   logic               coast_stop;
   logic               ramp_stop;
   logic               fault_reset;
   logic [3:0]         vin;
   logic signed [31:0] freq_delta;
   logic [6:0]         outs;
   logic [31:0]        rd;
   logic               v;
   int                 errors  = 0;
   int                 n_tests = 0;
   int                 n_pul   = 0;
   int                 cnt;
   int                 k;
   fcs_if link ();
   fcs_drive_end #(.SAMPLE_CYCLES(SAMP)) i_fcs_drive_end
   (
      .ref_clk(ref_clk), .rst_n(rst_n), .link(link), .bypass_mode(byp),
      .status_word_select(sel), .app_status_word(app), .local_on(lon),
      .local_fault_reset(lfr), .ready_switch_on(sts[0]), .ready_operate(sts[1]),
      .running(sts[2]), .fault_active(sts[3]), .warning_active(sts[4]),
      .auto_reset_fault(sts[5]), .switch_inhibit(sts[6]), .speed_at_ref(sts[7]),
      .fout_over_fmax(sts[8]), .freq_ref(fref), .drive_on(drive_on), .coast_stop(coast_stop),
      .ramp_stop(ramp_stop), .fault_reset(fault_reset), .bus_virtual_inputs(vin),
      .freq_delta(freq_delta)
   );
   fcs_bus_master #(.WDOG_PERIOD(WDP)) i_fcs_bus_master
   (
      .ref_clk(ref_clk), .rst_n(rst_n), .link(link), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
   );
   fcs_link_checker i_fcs_link_checker
   (
      .ref_clk(ref_clk), .rst_n(rst_n), .fieldbus_command_word(link.fieldbus_command_word),
      .fieldbus_drive_state_word(link.fieldbus_drive_state_word),
      .logger_trigger_flags(link.logger_trigger_flags), .bypass_mode(byp),
      .status_word_select(sel), .app_status_word(app), .fault_active(sts[3]),
      .warning_active(sts[4]), .auto_reset_fault(sts[5])
   );
   assign outs = {vin, ramp_stop, coast_stop, drive_on};
   // clock
   always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
   // count cycles with fault reset high
   always @(posedge ref_clk)
   begin
      if (fault_reset === 1'b1)
         n_pul++;
   end
   // expected profile word in bypass
   function automatic logic [15:0] exp_st(input logic [15:0] c, input logic [8:0] s);
      exp_st = {c[11], 4'h0, s[8], c[10], s[7], s[4], s[6], c[2], c[1], s[3:0]};
   endfunction
   // expected logger trigger word
   function automatic logic [15:0] exp_tr(input logic [8:0] s);
      exp_tr = {11'h0, s[3] | s[5], s[3] | s[4], s[5], s[4], s[3]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // single word transfer, read data left in rd
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk({31'h0, hresp}, {31'h0, HRESP_OKAY}); // response always okay
   endtask
   task automatic report_and_stop();
      if (errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // hang guard
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      report_and_stop();
   end
   // main sequence
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      cnt = 0;
      while (freq_delta === 32'sh0 && cnt < 200)
      begin
         @(posedge ref_clk);
         cnt++;
      end
      chk(freq_delta, 32'(10 * SCL));
      chk({25'h0, outs}, 32'h0);
      ahb(1'b1, 8'h40, 32'hFFFF);
      ahb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b0, OFS_CMD, 32'h0);
      chk(rd, {16'h0, CMD_RESET});
      foreach (ROWS[i])
      begin
         @(posedge ref_clk);
         sts <= ROWS[i].sts;
         ahb(1'b1, OFS_CMD, {16'h0, ROWS[i].cmd});
         repeat (4) @(posedge ref_clk);
         chk({25'h0, outs}, {25'h0, ROWS[i].outs});
         ahb(1'b0, OFS_STAT, 32'h0);
         chk(rd, {16'h0, exp_st(ROWS[i].cmd, ROWS[i].sts)});
         ahb(1'b0, OFS_TRIG, 32'h0);
         chk(rd, {16'h0, exp_tr(ROWS[i].sts)});
      end
      // fault reset: edge, steady level, back-to-back edge
      k = n_pul;
      ahb(1'b1, OFS_CMD, 32'h0087);
      repeat (4) @(posedge ref_clk);
      chk(32'(n_pul), 32'(k + 1));
      ahb(1'b1, OFS_CMD, 32'h0087);
      repeat (4) @(posedge ref_clk);
      chk(32'(n_pul), 32'(k + 1));
      ahb(1'b1, OFS_CMD, 32'h0007);
      ahb(1'b1, OFS_CMD, 32'h0087);
      repeat (4) @(posedge ref_clk);
      chk(32'(n_pul), 32'(k + 2));
      // local control outside bypass
      @(posedge ref_clk);
      byp <= 1'b0;
      lon <= 1'b1;
      sts <= 9'h0;
      ahb(1'b1, OFS_CMD, 32'h0C00);
      repeat (4) @(posedge ref_clk);
      chk({25'h0, outs}, 32'h01);
      chk({31'h0, fault_reset}, 32'h1);
      ahb(1'b0, OFS_STAT, 32'h0);
      chk(rd, 32'h0030);
      // echo register: no echo while the bus word is ignored
      ahb(1'b0, OFS_ECHO, 32'h0);
      chk(rd, 32'h0);
      byp <= 1'b1;
      lon <= 1'b0;
      lfr <= 1'b0;
      sel <= 1'b0;
      app <= 16'hA5C3;
      ahb(1'b0, OFS_STAT, 32'h0);
      chk(rd, 32'hA5C3);
      sel <= 1'b1;
      // rate of change after a step of 3
      cnt = 0;
      while (freq_delta !== 32'sh0 && cnt < 250)
      begin
         @(posedge ref_clk);
         cnt++;
      end
      fref <= 16'sd13;
      cnt = 0;
      while (freq_delta === 32'sh0 && cnt < 250)
      begin
         @(posedge ref_clk);
         cnt++;
      end
      chk(freq_delta, 32'(3 * SCL));
      // master watchdog toggling of virtual input 1
      ahb(1'b1, OFS_WDOG, 32'h1);
      for (int p = 0; p < 2; p++)
      begin
         v   = vin[0];
         cnt = 0;
         while (vin[0] === v && cnt < 40)
         begin
            @(posedge ref_clk);
            cnt++;
         end
      end
      chk(32'(cnt), 32'(WDP));
      ahb(1'b0, OFS_WDOG, 32'h0);
      chk(rd, 32'h1);
      // mid-run reset: outputs, state and trigger words cleared, command word back to reset value
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk({25'h0, outs}, 32'h0);
      chk({link.fieldbus_drive_state_word, link.logger_trigger_flags}, 32'h0);
      chk(freq_delta, 32'h0);
      rst_n <= 1'b1;
      ahb(1'b0, OFS_CMD, 32'h0);
      chk(rd, {16'h0, CMD_RESET});
      ahb(1'b0, OFS_ECHO, 32'h0);
      chk(rd, 32'h1);
      report_and_stop();
   end
endmodule
`default_nettype wire
